// ===== design/egcg_top.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ns
// What this block does
// - Three-bit code selects gain, 3 dB steps
// - Separate gain field for each port
// - Pad bit forces 12 dB receive attenuation
// - Outputs drive only when bit and pin
// - Drive enable exists only in group 0
// - Global mask silences all tone interrupts
// - B mask silences tone detector B interrupt
module egcg_top #(
   parameter int GROUPS = egcg_pkg::GROUPS_DEF
) (
   input wire logic CORE_CLK, // 125 MHz clock
   input wire logic RESET, // Synchronous, active high
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB enable
   input wire logic PWRITE, // APB direction
   input wire logic [12:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error
   input wire logic OUT_EN_PIN, // External output enable pin
   input wire logic [GROUPS-1:0] TONE_A_DET, // Tone detector A event
   input wire logic [GROUPS-1:0] TONE_B_DET, // Tone detector B event
   output logic [GROUPS-1:0] TONE_IRQ, // Tone interrupt per group
   output logic DATA_OUT_OE, // Rout/Sout drive enable
   output logic [GROUPS-1:0] GROUP_POWER_ON, // Group active
   output logic [GROUPS-1:0] LAW_SEL, // PCM law select
   output logic [GROUPS-1:0] FORMAT_SEL, // PCM format select
   output logic [2*GROUPS*6-1:0] RIN_GAIN_DB, // Receive-in gain per canceller
   output logic [2*GROUPS*6-1:0] ROUT_GAIN_DB, // Receive-out gain per canceller
   output logic [2*GROUPS*6-1:0] SIN_GAIN_DB, // Send-in gain per canceller
   output logic [2*GROUPS*6-1:0] SOUT_GAIN_DB // Send-out gain per canceller
);
   localparam int NC = 2 * GROUPS;

   if (GROUPS < 1 || GROUPS > egcg_pkg::GROUPS_MAX) begin : g_bad
      $error("GROUPS out of range");
   end

   typedef struct packed {
      logic [NC-1:0][2:0] rin;
      logic [NC-1:0][2:0] rout;
      logic [NC-1:0][2:0] sin;
      logic [NC-1:0][2:0] sout;
      logic [NC-1:0][7:0] ctl1;
      logic [GROUPS-1:0][4:0] main_lo;
      logic tone_irq_mask_global;
      logic output_drive_enable;
      logic wr_all;
      logic [2:0] pin_sync;
      logic pin_ok;
      logic ready;
      logic err;
      logic [31:0] rdata;
      logic oe;
      logic [GROUPS-1:0] irq;
      logic [NC-1:0][5:0] rin_db;
      logic [NC-1:0][5:0] rout_db;
      logic [NC-1:0][5:0] sin_db;
      logic [NC-1:0][5:0] sout_db;
   } egcg_state_t;

   egcg_state_t q;
   egcg_state_t d;
   logic [NC-1:0][5:0] dec_rin;
   logic [NC-1:0][5:0] dec_rout;
   logic [NC-1:0][5:0] dec_sin;
   logic [NC-1:0][5:0] dec_sout;

   for (genvar c = 0; c < NC; c++) begin : g_dec
      egcg_gain_dec u_dec (
         .rin_code(q.rin[c]),
         .rout_code(q.rout[c]),
         .sin_code(q.sin[c]),
         .sout_code(q.sout[c]),
         .pad(q.ctl1[c][egcg_pkg::CTL1_PAD_BIT]),
         .rin_db(dec_rin[c]),
         .rout_db(dec_rout[c]),
         .sin_db(dec_sin[c]),
         .sout_db(dec_sout[c])
      );
   end

   function automatic logic mapped(input logic [10:0] idx);
      logic hit;
      hit = 1'b0;
      if (idx >= egcg_pkg::IDX_MAIN0 && int'(idx) < int'(egcg_pkg::IDX_MAIN0) + GROUPS) begin
         hit = 1'b1;
      end else if (int'(idx[10:5]) < NC) begin
         hit = (idx[4:0] == egcg_pkg::OFF_CTL1) || (idx[4:0] == egcg_pkg::OFF_GAIN_TX) ||
               (idx[4:0] == egcg_pkg::OFF_GAIN_RX);
      end
      return hit;
   endfunction

   always_comb begin
      logic [10:0] idx;
      logic ok;
      logic setup;
      logic wr;
      logic hit;
      int c;
      int g;
      hit = 1'b0;
      idx = PADDR[12:2];
      ok = (PADDR[1:0] == 2'h0) && mapped(idx);
      setup = PSEL && !PENABLE && !q.ready;
      wr = PSEL && PENABLE && q.ready && PWRITE && ok;
      c = int'(idx[10:5]);
      g = int'(idx) - int'(egcg_pkg::IDX_MAIN0);
      d = q;
      // Answer is registered at the end of setup so the slave adds no wait state
      d.ready = setup;
      d.err = setup && !ok;
      d.rdata = '0;
      if (setup && ok && !PWRITE) begin
         if (idx >= egcg_pkg::IDX_MAIN0) begin
            d.rdata[4:0] = q.main_lo[g];
            if (g == 0) begin
               d.rdata[egcg_pkg::MC_TONE_IRQ_MASK_GLOBAL] = q.tone_irq_mask_global;
               d.rdata[egcg_pkg::MC_ODE] = q.output_drive_enable;
               d.rdata[egcg_pkg::MC_WRALL] = q.wr_all;
            end
         end else if (idx[4:0] == egcg_pkg::OFF_CTL1) begin
            d.rdata[7:0] = q.ctl1[c];
         end else if (idx[4:0] == egcg_pkg::OFF_GAIN_TX) begin
            d.rdata[egcg_pkg::GAIN_IN_LSB +: 3] = q.sin[c];
            d.rdata[egcg_pkg::GAIN_OUT_LSB +: 3] = q.sout[c];
         end else begin
            d.rdata[egcg_pkg::GAIN_IN_LSB +: 3] = q.rin[c];
            d.rdata[egcg_pkg::GAIN_OUT_LSB +: 3] = q.rout[c];
         end
      end
      for (int k = 0; k < NC; k++) begin
         hit = wr && idx < egcg_pkg::IDX_MAIN0 &&
               ((int'(idx[10:5]) == k) || (q.wr_all && idx[10:6] == '0 && idx[5] == k[0]));
         if (hit) begin
            case (idx[4:0])
               egcg_pkg::OFF_CTL1: d.ctl1[k] = PWDATA[7:0];
               egcg_pkg::OFF_GAIN_TX: begin
                  d.sin[k] = PWDATA[egcg_pkg::GAIN_IN_LSB +: 3];
                  d.sout[k] = PWDATA[egcg_pkg::GAIN_OUT_LSB +: 3];
               end
               egcg_pkg::OFF_GAIN_RX: begin
                  d.rin[k] = PWDATA[egcg_pkg::GAIN_IN_LSB +: 3];
                  d.rout[k] = PWDATA[egcg_pkg::GAIN_OUT_LSB +: 3];
               end
               default: ;
            endcase
         end
      end
      if (wr && idx >= egcg_pkg::IDX_MAIN0) begin
         d.main_lo[g] = PWDATA[4:0];
         // Other groups have no global bits to write
         if (g == 0) begin
            d.tone_irq_mask_global = PWDATA[egcg_pkg::MC_TONE_IRQ_MASK_GLOBAL];
            d.output_drive_enable = PWDATA[egcg_pkg::MC_ODE];
            d.wr_all = PWDATA[egcg_pkg::MC_WRALL];
         end
      end
      // Pin change accepted once stages two and three agree
      d.pin_sync = {q.pin_sync[1:0], OUT_EN_PIN};
      if (q.pin_sync[1] == q.pin_sync[2]) begin
         d.pin_ok = q.pin_sync[2];
      end
      d.oe = q.output_drive_enable && q.pin_ok;
      for (int k = 0; k < GROUPS; k++) begin
         d.irq[k] = !q.tone_irq_mask_global &&
            ((TONE_A_DET[k] && !q.main_lo[k][egcg_pkg::MC_MTDA]) ||
             (TONE_B_DET[k] && !q.main_lo[k][egcg_pkg::MC_MTDB]));
      end
      d.rin_db = dec_rin;
      d.rout_db = dec_rout;
      d.sin_db = dec_sin;
      d.sout_db = dec_sout;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         q <= '0;
         q.rin <= {NC{egcg_pkg::GAIN_CODE_DEF}};
         q.rout <= {NC{egcg_pkg::GAIN_CODE_DEF}};
         q.sin <= {NC{egcg_pkg::GAIN_CODE_DEF}};
         q.sout <= {NC{egcg_pkg::GAIN_CODE_DEF}};
         q.ctl1 <= {NC{egcg_pkg::CTL1_RST}};
      end else begin
         q <= d;
      end
   end

   assign PRDATA = q.rdata;
   assign PREADY = q.ready;
   assign PSLVERR = q.err;
   assign TONE_IRQ = q.irq;
   assign DATA_OUT_OE = q.oe;
   assign RIN_GAIN_DB = q.rin_db;
   assign ROUT_GAIN_DB = q.rout_db;
   assign SIN_GAIN_DB = q.sin_db;
   assign SOUT_GAIN_DB = q.sout_db;
   always_comb begin
      for (int k = 0; k < GROUPS; k++) begin
         GROUP_POWER_ON[k] = q.main_lo[k][egcg_pkg::MC_GROUP_POWER_ON];
         LAW_SEL[k] = q.main_lo[k][egcg_pkg::MC_LAW];
         FORMAT_SEL[k] = q.main_lo[k][egcg_pkg::MC_FORMAT];
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   AST_GAIN_MAX: assert property (
      q.rin[0] == egcg_pkg::GAIN_CODE_MAX && !q.ctl1[0][egcg_pkg::CTL1_PAD_BIT]
      |=> $signed(RIN_GAIN_DB[5:0]) == egcg_pkg::MAX_DB)
      else $error("Top gain code not +9 dB");
   AST_GAIN_MIN: assert property (
      q.rout[0] == egcg_pkg::GAIN_CODE_MIN && !q.ctl1[0][egcg_pkg::CTL1_PAD_BIT]
      |=> $signed(ROUT_GAIN_DB[5:0]) == egcg_pkg::PAD_DB)
      else $error("Bottom gain code not -12 dB");
   AST_GAIN_WRITE: assert property (
      PSEL && PENABLE && PREADY && PWRITE && PADDR == 13'h0070 && !q.wr_all
      |=> ##1 SOUT_GAIN_DB[5:0] == 6'(3 * int'($past(PWDATA[2:0], 2)) - 12))
      else $error("Send-out gain field not applied");
   AST_PAD: assert property (
      q.ctl1[0][egcg_pkg::CTL1_PAD_BIT]
      |=> $signed(RIN_GAIN_DB[5:0]) == egcg_pkg::PAD_DB && ROUT_GAIN_DB[5:0] == 6'h00)
      else $error("Pad did not override receive path");
   AST_BCAST: assert property (
      PSEL && PENABLE && PREADY && PWRITE && q.wr_all && PADDR[1:0] == 2'h0 &&
      PADDR[12:2] == egcg_pkg::IDX_GAIN_RX0
      |=> q.rin[NC-2] == $past(PWDATA[6:4]))
      else $error("Broadcast write missed last group");
   AST_OE: assert property (
      DATA_OUT_OE |-> $past(q.output_drive_enable) && $past(q.pin_ok))
      else $error("Outputs enabled without bit and pin");
   AST_ODE_G0: assert property (
      PSEL && PENABLE && PREADY && PWRITE && PADDR[12:2] != egcg_pkg::IDX_MAIN0
      |=> q.output_drive_enable == $past(q.output_drive_enable))
      else $error("Drive enable changed by another register");
   AST_TONE_IRQ_MASK_GLOBAL: assert property (
      q.tone_irq_mask_global |=> TONE_IRQ == '0)
      else $error("Tone interrupt passed global mask");
   AST_MTDB: assert property (
      q.main_lo[0][egcg_pkg::MC_MTDB] && !TONE_A_DET[0] |=> !TONE_IRQ[0])
      else $error("Tone B interrupt passed its mask");
   AST_READY_PULSE: assert property (
      PREADY |=> !PREADY)
      else $error("Ready held longer than one cycle");
endmodule

// ===== design/egcg_pkg.sv
package egcg_pkg;
   // Register index space: byte address on APB is four times the index
   localparam int IDX_W = 11;
   localparam int ADDR_W = 13;
   localparam int GROUPS_DEF = 8;
   localparam int GROUPS_MAX = 8;
   localparam logic [10:0] IDX_MAIN0 = 11'h400;
   localparam logic [10:0] IDX_GAIN_RX0 = 11'h01d;
   localparam logic [4:0] OFF_CTL1 = 5'h00;
   localparam logic [4:0] OFF_GAIN_TX = 5'h1c;
   localparam logic [4:0] OFF_GAIN_RX = 5'h1d;
   // Gain register fields
   localparam int GAIN_W = 3;
   localparam int GAIN_IN_LSB = 4;
   localparam int GAIN_OUT_LSB = 0;
   localparam logic [2:0] GAIN_CODE_DEF = 3'h4;
   localparam logic [2:0] GAIN_CODE_MAX = 3'h7;
   localparam logic [2:0] GAIN_CODE_MIN = 3'h0;
   // Control register 1
   localparam logic [7:0] CTL1_RST = 8'h00;
   localparam int CTL1_PAD_BIT = 7;
   // Main control register fields
   localparam logic [7:0] MAIN_RST = 8'h00;
   localparam int MC_LO_W = 5;
   localparam int MC_GROUP_POWER_ON = 0;
   localparam int MC_LAW = 1;
   localparam int MC_FORMAT = 2;
   localparam int MC_MTDA = 3;
   localparam int MC_MTDB = 4;
   localparam int MC_TONE_IRQ_MASK_GLOBAL = 5;
   localparam int MC_ODE = 6;
   localparam int MC_WRALL = 7;
   // Gain in dB, two's complement
   localparam int DB_W = 6;
   localparam int GAIN_STEP_DB = 3;
   localparam int GAIN_MIN_DB = -12;
   localparam logic signed [5:0] PAD_DB = -6'sd12;
   localparam logic signed [5:0] UNITY_DB = 6'sd0;
   localparam logic signed [5:0] MAX_DB = 6'sd9;
endpackage

// ===== design/egcg_gain_dec.sv
`timescale 1ns/1ns
module egcg_gain_dec (
   input wire logic [2:0] rin_code, // Receive-in gain code
   input wire logic [2:0] rout_code, // Receive-out gain code
   input wire logic [2:0] sin_code, // Send-in gain code
   input wire logic [2:0] sout_code, // Send-out gain code
   input wire logic pad, // Fixed receive path attenuation
   output logic signed [5:0] rin_db, // Receive-in gain
   output logic signed [5:0] rout_db, // Receive-out gain
   output logic signed [5:0] sin_db, // Send-in gain
   output logic signed [5:0] sout_db // Send-out gain
);
   function automatic logic signed [5:0] db_of(input logic [2:0] code);
      db_of = 6'(egcg_pkg::GAIN_STEP_DB * int'(code) + egcg_pkg::GAIN_MIN_DB);
   endfunction

   // Pad replaces the whole receive path setting, not just one stage
   always_comb begin
      rin_db = pad ? egcg_pkg::PAD_DB : db_of(rin_code);
      rout_db = pad ? egcg_pkg::UNITY_DB : db_of(rout_code);
      sin_db = db_of(sin_code);
      sout_db = db_of(sout_code);
   end
endmodule

// ===== tb/tb_egcg_top.sv
`timescale 1ns/1ns
module tb_egcg_top;
   localparam int G = 8;
   logic CORE_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [12:0] PADDR = 13'h0000;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, DATA_OUT_OE, OUT_EN_PIN = 1'b0;
   logic [G-1:0] TONE_A_DET = '0, TONE_B_DET = '0, TONE_IRQ, GROUP_POWER_ON, LAW_SEL, FORMAT_SEL;
   logic [2*G*6-1:0] RIN_GAIN_DB, ROUT_GAIN_DB, SIN_GAIN_DB, SOUT_GAIN_DB;
   int n_fail = 0, compares = 0;
   logic [31:0] rd;
   logic err;

   egcg_top #(.GROUPS(G)) DUT (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .OUT_EN_PIN(OUT_EN_PIN), .TONE_A_DET(TONE_A_DET),
      .TONE_B_DET(TONE_B_DET), .TONE_IRQ(TONE_IRQ), .DATA_OUT_OE(DATA_OUT_OE),
      .GROUP_POWER_ON(GROUP_POWER_ON), .LAW_SEL(LAW_SEL), .FORMAT_SEL(FORMAT_SEL),
      .RIN_GAIN_DB(RIN_GAIN_DB),
      .ROUT_GAIN_DB(ROUT_GAIN_DB), .SIN_GAIN_DB(SIN_GAIN_DB), .SOUT_GAIN_DB(SOUT_GAIN_DB));

   initial begin
      forever #4 CORE_CLK = ~CORE_CLK;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask

   // Idle edge before setup so a release and a new request never share a time step
   task automatic apb(input logic w, input logic [10:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {idx, 2'b00};
      PWDATA <= {24'h000000, d};
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 50) n_fail++;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   function automatic logic [31:0] db(input int code);
      logic [5:0] v;
      v = 6'(3 * code - 12);
      return {26'h0000000, v};
   endfunction

   task automatic stop_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      cyc(20000);
      n_fail++;
      stop_test();
   end

   initial begin
      cyc(6);
      RESET <= 1'b0;
      apb(1'b0, 11'h400, 8'h00);
      chk("main0 reset", 32'h0000_0000, rd);
      apb(1'b0, 11'h01d, 8'h00);
      chk("gain reset", 32'h0000_0044, rd);
      chk("rin reset db", db(4), {26'h0, RIN_GAIN_DB[5:0]});
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, 11'h01d, {1'b0, 3'(k), 1'b0, 3'(7 - k)});
         apb(1'b1, 11'h01c, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
         cyc(3);
         chk("rin db", db(k), {26'h0, RIN_GAIN_DB[5:0]});
         chk("rout db", db(7 - k), {26'h0, ROUT_GAIN_DB[5:0]});
         chk("sin db", db(7 - k), {26'h0, SIN_GAIN_DB[5:0]});
         chk("sout db", db(k), {26'h0, SOUT_GAIN_DB[5:0]});
      end
      apb(1'b1, 11'h03d, 8'h40);
      cyc(3);
      chk("rin b db", db(4), {26'h0, RIN_GAIN_DB[11:6]});
      chk("rin a kept", db(7), {26'h0, RIN_GAIN_DB[5:0]});
      $display("test gains done");
      apb(1'b1, 11'h000, 8'h80);
      cyc(3);
      chk("pad rin", db(0), {26'h0, RIN_GAIN_DB[5:0]});
      chk("pad rout", db(4), {26'h0, ROUT_GAIN_DB[5:0]});
      apb(1'b1, 11'h000, 8'h00);
      cyc(3);
      chk("unpad rout", db(0), {26'h0, ROUT_GAIN_DB[5:0]});
      $display("test pad done");
      apb(1'b1, 11'h400, 8'h80);
      apb(1'b1, 11'h01d, 8'h26);
      cyc(3);
      for (int g = 0; g < G; g++) begin
         chk("bcast rin", db(2), {26'h0, RIN_GAIN_DB[12*g +: 6]});
      end
      apb(1'b1, 11'h400, 8'h00);
      apb(1'b1, 11'h01d, 8'h44);
      cyc(3);
      chk("no bcast g0", db(4), {26'h0, RIN_GAIN_DB[5:0]});
      chk("no bcast g7", db(2), {26'h0, RIN_GAIN_DB[12*(G-1) +: 6]});
      $display("test broadcast done");
      apb(1'b1, 11'h400, 8'h40);
      cyc(6);
      chk("oe pin low", 32'h0, {31'h0, DATA_OUT_OE});
      OUT_EN_PIN <= 1'b1;
      cyc(6);
      chk("oe both", 32'h1, {31'h0, DATA_OUT_OE});
      apb(1'b1, 11'h400, 8'h00);
      cyc(3);
      chk("oe bit low", 32'h0, {31'h0, DATA_OUT_OE});
      apb(1'b1, 11'h401, 8'hff);
      apb(1'b0, 11'h401, 8'h00);
      chk("main1 read", 32'h0000_001f, rd);
      cyc(3);
      chk("oe other grp", 32'h0, {31'h0, DATA_OUT_OE});
      chk("power g1", 32'h1, {31'h0, GROUP_POWER_ON[1]});
      chk("law g1", 32'h1, {31'h0, LAW_SEL[1]});
      chk("format g1", 32'h1, {31'h0, FORMAT_SEL[1]});
      chk("power g0", 32'h0, {31'h0, GROUP_POWER_ON[0]});
      apb(1'b1, 11'h401, 8'h00);
      $display("test drive enable done");
      TONE_B_DET[0] <= 1'b1;
      cyc(3);
      chk("irq b", 32'h1, {31'h0, TONE_IRQ[0]});
      apb(1'b1, 11'h400, 8'h10);
      cyc(3);
      chk("irq b masked", 32'h0, {31'h0, TONE_IRQ[0]});
      TONE_A_DET[0] <= 1'b1;
      cyc(3);
      chk("irq a", 32'h1, {31'h0, TONE_IRQ[0]});
      apb(1'b1, 11'h400, 8'h30);
      cyc(3);
      chk("irq global", 32'h0, {31'h0, TONE_IRQ[0]});
      apb(1'b0, 11'h400, 8'h00);
      chk("main0 read", 32'h0000_0030, rd);
      apb(1'b1, 11'h400, 8'h00);
      cyc(3);
      chk("irq unmask", 32'h1, {31'h0, TONE_IRQ[0]});
      apb(1'b1, 11'h400, 8'h08);
      cyc(3);
      chk("irq b live", 32'h1, {31'h0, TONE_IRQ[0]});
      TONE_B_DET[0] <= 1'b0;
      cyc(3);
      chk("irq a masked", 32'h0, {31'h0, TONE_IRQ[0]});
      $display("test interrupts done");
      apb(1'b1, 11'h7ff, 8'h55);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b0, 11'h7ff, 8'h00);
      chk("unmapped data", 32'h0, rd);
      $display("test unmapped done");
      stop_test();
   end
endmodule
